// >>> verilog/io_bank_pkg.sv
/*
 * Shared constants and types for the configurable I/O port bank.
 * Assumes a single 50 MHz clock domain and synchronous pin inputs.
 */
package io_bank_pkg;

    // ==========================================================
    // Geometry
    localparam int PORT_COUNT   = 4;
    localparam int PORT_WIDTH   = 8;
    localparam int PIN_COUNT    = 26;
    localparam int LAST_PORT_W  = 2;

    // Flat pin index of port p, bit b is p*8+b; port 3 has bits 0..1
    localparam int PIN_RESET    = 13;
    localparam int PIN_TWI_SCL  = 10;
    localparam int PIN_TWI_SDA  = 11;
    localparam int PIN_IRQ_A    = 11;
    localparam int PIN_IRQ_B    = 12;
    localparam int PIN_TIMER_A  = 10;
    localparam int PIN_XTAL_OUT = 24;
    localparam int PIN_XTAL_IN  = 25;

    // ==========================================================
    // Modes, encoded {mode_sel_hi, mode_sel_lo}
    typedef enum logic [1:0] {
        MODE_QUASI     = 2'h0,
        MODE_PUSH_PULL = 2'h1,
        MODE_INPUT     = 2'h2,
        MODE_OPEN      = 2'h3
    } pin_mode_e;

    localparam logic [1:0] MODE_RESET = 2'h2;

    // ==========================================================
    // Timing
    localparam int CLOCK_HZ         = 50_000_000;
    localparam int STRONG_PU_CYCLES = 2;
    localparam int GLITCH_NS        = 60;
    localparam int GLITCH_CYCLES    =
        ((GLITCH_NS * (CLOCK_HZ / 1_000_000)) + 999) / 1000;

    // ==========================================================
    // Pin driver controls for one pin
    typedef struct packed {
        logic very_weak_pu;
        logic weak_pu;
        logic strong_pu;
        logic pull_down;
    } pin_drive_s;

endpackage

// >>> verilog/glitch_filter.sv
/*
 * Glitch suppressor for one pin: output follows input only after the
 * input has held a new level for FILTER_CYCLES consecutive clocks.
 * Assumes input already synchronous to clock_i.
 */
`timescale 1ns/1ps

module glitch_filter
    import io_bank_pkg::*;
#(
    parameter int FILTER_CYCLES = GLITCH_CYCLES
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic raw_i,
    output logic      clean_o
);

    // Counter is 8 bits wide, so longer filters cannot be served
    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_filter
        $error("glitch_filter: FILTER_CYCLES out of range");
    end

    logic [7:0] count;
    logic [7:0] next_count;
    logic       level;
    logic       next_level;

    // ==========================================================
    // Filter
    always_comb begin
        next_level = level;
        next_count = 8'h00;
        if (raw_i != level) begin
            if (count + 8'h01 >= 8'(FILTER_CYCLES)) begin
                next_level = raw_i;
            end else begin
                next_count = count + 8'h01;
            end
        end
    end

    // Reset to low: pins start undriven
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 8'h00;
            level <= 1'b0;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end

    assign clean_o = level;

endmodule

// >>> verilog/io_port_bank.sv
/*
 * Bank of four GPIO ports (8, 8, 8 and 2 pins) with per-pin output mode
 * and pull-up / pull-down driver control.
 * Assumes pin levels arrive synchronous to clock_i; the analog drivers
 * outside act on the pin_drive_s controls per pin.
 */
`timescale 1ns/1ps

// Operation
// - Three eight-pin ports plus one two-pin port, 26 pins total.
// - Two mode bits per pin: quasi, push-pull, input-only, open drain.
// - Reset-shared pin on port 1 bit 5 is always input.
// - Two-wire pins port 1 bits 2,3 allow only input-only or open drain.
// - Quasi mode: latch 1 drives weakly high, latch 0 strongly low.
// - Quasi mode: very weak pull-up on whenever latch holds 1.
// - Quasi mode: weak pull-up on only when latch and pin are 1.
// - Quasi mode: latch rising 0 to 1 gives strong pull-up two clocks.
// - Open drain: no pull-ups; pull-down only while latch holds 0.
// - Inputs glitch filtered except two-wire pins; irq b filtered.
// - Usable pin count depends on clock source and reset option.
// - Push-pull: continuous strong pull-up on latch 1, pull-down on 0.
// - All pins start in input-only mode after reset.
module io_port_bank
    import io_bank_pkg::*;
#(
    parameter int FILTER_CYCLES = GLITCH_CYCLES
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic [PIN_COUNT-1:0]   latch_wr_data_i,
    input  wire logic [PIN_COUNT-1:0]   latch_wr_en_i,
    input  wire logic [PIN_COUNT-1:0]   mode_sel_hi_wr_i,
    input  wire logic [PIN_COUNT-1:0]   mode_sel_lo_wr_i,
    input  wire logic [PIN_COUNT-1:0]   mode_wr_en_i,
    input  wire logic                   ext_reset_pin_en_i,
    input  wire logic                   crystal_osc_en_i,
    input  wire logic [PIN_COUNT-1:0]   pin_level_i,
    output pin_drive_s [PIN_COUNT-1:0]  pin_drive_o,
    output logic [PIN_COUNT-1:0]        port_read_o,
    output logic [PIN_COUNT-1:0]        latch_o,
    output logic [PIN_COUNT-1:0]        mode_sel_hi_o,
    output logic [PIN_COUNT-1:0]        mode_sel_lo_o,
    output logic                        ext_irq_a_input_o,
    output logic                        ext_irq_b_input_o,
    output logic                        timer_a_count_input_o,
    output logic [4:0]                  usable_pins_o
);

    if (FILTER_CYCLES < 1 || FILTER_CYCLES > 255) begin : g_bad_filter
        $error("io_port_bank: FILTER_CYCLES out of range");
    end

    // Restricted pins never hold quasi or push-pull
    function automatic logic [1:0] legal_mode(input int idx, input logic [1:0] m);
        logic [1:0] r;
        r = m;
        if (idx == PIN_RESET) begin
            r = MODE_RESET;
        end else if ((idx == PIN_TWI_SCL || idx == PIN_TWI_SDA) && !m[1]) begin
            r = MODE_RESET;
        end
        return r;
    endfunction

    // ==========================================================
    // Latch, mode and strong pull-up state
    logic [PIN_COUNT-1:0] latch;
    logic [PIN_COUNT-1:0] next_latch;
    logic [PIN_COUNT-1:0] m_hi;
    logic [PIN_COUNT-1:0] next_m_hi;
    logic [PIN_COUNT-1:0] m_lo;
    logic [PIN_COUNT-1:0] next_m_lo;
    logic [1:0]           spu_cnt      [PIN_COUNT];
    logic [1:0]           next_spu_cnt [PIN_COUNT];
    logic [PIN_COUNT-1:0] sensed;

    always_comb begin
        logic [1:0] m;
        m = 2'h0;
        next_latch = latch;
        next_m_hi  = m_hi;
        next_m_lo  = m_lo;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (latch_wr_en_i[i]) begin
                next_latch[i] = latch_wr_data_i[i];
            end
            if (mode_wr_en_i[i]) begin
                m = legal_mode(i, {mode_sel_hi_wr_i[i], mode_sel_lo_wr_i[i]});
                next_m_hi[i] = m[1];
                next_m_lo[i] = m[0];
            end
            // Strong pulse counts from the latch edge itself
            if (!latch[i] && next_latch[i] && {m_hi[i], m_lo[i]} == MODE_QUASI) begin
                next_spu_cnt[i] = 2'(STRONG_PU_CYCLES);
            end else if (spu_cnt[i] != 2'h0) begin
                next_spu_cnt[i] = spu_cnt[i] - 2'h1;
            end else begin
                next_spu_cnt[i] = 2'h0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latch <= '1;
            m_hi  <= '1;
            m_lo  <= '0;
            for (int i = 0; i < PIN_COUNT; i++) begin
                spu_cnt[i] <= 2'h0;
            end
        end else begin
            latch <= next_latch;
            m_hi  <= next_m_hi;
            m_lo  <= next_m_lo;
            for (int i = 0; i < PIN_COUNT; i++) begin
                spu_cnt[i] <= next_spu_cnt[i];
            end
        end
    end

    // ==========================================================
    // Input path
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_in
            if (g == PIN_TWI_SCL || g == PIN_TWI_SDA) begin : g_raw
                // Two-wire pins bypass the filter to keep bus timing
                assign sensed[g] = pin_level_i[g];
            end else begin : g_filt
                glitch_filter #(
                    .FILTER_CYCLES(FILTER_CYCLES)
                ) u_filt (
                    .clock_i (clock_i),
                    .rst_n_i (rst_n_i),
                    .raw_i   (pin_level_i[g]),
                    .clean_o (sensed[g])
                );
            end
        end
    endgenerate

    // ==========================================================
    // Driver decode
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pin_drive_o[i] = '0;
            case ({m_hi[i], m_lo[i]})
                MODE_QUASI: begin
                    pin_drive_o[i].very_weak_pu = latch[i];
                    pin_drive_o[i].weak_pu      = latch[i] & sensed[i];
                    pin_drive_o[i].strong_pu    = spu_cnt[i] != 2'h0;
                    pin_drive_o[i].pull_down    = !latch[i];
                end
                MODE_PUSH_PULL: begin
                    pin_drive_o[i].strong_pu = latch[i];
                    pin_drive_o[i].pull_down = !latch[i];
                end
                MODE_OPEN: begin
                    pin_drive_o[i].pull_down = !latch[i];
                end
                MODE_INPUT: begin
                    pin_drive_o[i] = '0;
                end
                default: begin
                    pin_drive_o[i] = '0;
                end
            endcase
        end
    end

    assign port_read_o           = sensed;
    assign latch_o               = latch;
    assign mode_sel_hi_o         = m_hi;
    assign mode_sel_lo_o         = m_lo;
    assign ext_irq_a_input_o     = sensed[PIN_IRQ_A];
    assign ext_irq_b_input_o     = sensed[PIN_IRQ_B];
    assign timer_a_count_input_o = sensed[PIN_TIMER_A];

    // Pins lost to crystal and reset functions
    assign usable_pins_o = 5'(PIN_COUNT)
        - (crystal_osc_en_i ? 5'h2 : 5'h0)
        - (ext_reset_pin_en_i ? 5'h1 : 5'h0);

    // ==========================================================
    // Checks
    property p_strong_two;
        @(posedge clock_i) disable iff (!rst_n_i)
        ($rose(latch[0]) && {m_hi[0], m_lo[0]} == MODE_QUASI && $stable({m_hi[0], m_lo[0]}))
        |-> pin_drive_o[0].strong_pu [*2] ##1 !pin_drive_o[0].strong_pu;
    endproperty
    a_strong_two: assert property (p_strong_two)
        else $error("strong pull-up not exactly two cycles");

    property p_reset_input;
        @(posedge clock_i) disable iff (!rst_n_i)
        {m_hi[PIN_RESET], m_lo[PIN_RESET]} == MODE_INPUT && pin_drive_o[PIN_RESET] == '0;
    endproperty
    a_reset_input: assert property (p_reset_input)
        else $error("reset pin left input mode");

    property p_twi_modes;
        @(posedge clock_i) disable iff (!rst_n_i)
        m_hi[PIN_TWI_SCL] && m_hi[PIN_TWI_SDA];
    endproperty
    a_twi_modes: assert property (p_twi_modes)
        else $error("two-wire pin in illegal mode");

    property p_open_nopu;
        @(posedge clock_i) disable iff (!rst_n_i)
        {m_hi[2], m_lo[2]} == MODE_OPEN |->
            !pin_drive_o[2].weak_pu && !pin_drive_o[2].strong_pu
            && pin_drive_o[2].pull_down == !latch[2];
    endproperty
    a_open_nopu: assert property (p_open_nopu)
        else $error("open drain drove a pull-up");

    property p_weak_pu;
        @(posedge clock_i) disable iff (!rst_n_i)
        ({m_hi[1], m_lo[1]} == MODE_QUASI && !sensed[1]) |-> !pin_drive_o[1].weak_pu;
    endproperty
    a_weak_pu: assert property (p_weak_pu)
        else $error("weak pull-up on with pin low");

    property p_push_pull;
        @(posedge clock_i) disable iff (!rst_n_i)
        {m_hi[0], m_lo[0]} == MODE_PUSH_PULL |->
            pin_drive_o[0].strong_pu == latch[0] && pin_drive_o[0].pull_down != latch[0];
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull drive wrong");

    property p_quasi_vw;
        @(posedge clock_i) disable iff (!rst_n_i)
        {m_hi[1], m_lo[1]} == MODE_QUASI |->
            pin_drive_o[1].very_weak_pu == latch[1] && pin_drive_o[1].pull_down == !latch[1];
    endproperty
    a_quasi_vw: assert property (p_quasi_vw)
        else $error("quasi very weak pull-up wrong");

    property p_filter_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        // A one-clock filter passes every change, so the check needs two or more
        (FILTER_CYCLES > 1) && $changed(pin_level_i[4]) ##1 $changed(pin_level_i[4])
            |-> $stable(sensed[4]);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("one-cycle glitch passed filter");

    property p_twi_raw;
        @(posedge clock_i) disable iff (!rst_n_i)
        port_read_o[PIN_TWI_SDA] == pin_level_i[PIN_TWI_SDA];
    endproperty
    a_twi_raw: assert property (p_twi_raw)
        else $error("two-wire pin read not raw level");

endmodule

// >>> tb/pin_world_model.sv
/*
 * Model of the circuits outside the pins: bench-set external sinks
 * and pull resistors, resolved against the bank's drive controls.
 * Assumes one clock and drive controls from io_port_bank.
 */
`timescale 1ns/1ps

module pin_world_model
    import io_bank_pkg::*;
(
    input  wire logic                  clock_i,
    input  wire pin_drive_s [PIN_COUNT-1:0] pin_drive_i,
    input  wire logic [PIN_COUNT-1:0]  ext_low_i,
    input  wire logic [PIN_COUNT-1:0]  ext_high_i,
    output logic [PIN_COUNT-1:0]       pin_level_o
);
    // ==========================================================
    // Pin resolution
    logic [PIN_COUNT-1:0] float_pat = '0;

    // Undriven pin wanders so a floating level is never taken for valid
    always @(posedge clock_i) begin
        float_pat <= ~float_pat;
    end

    // Sinks win over pull-ups; a resistor only holds an undriven pin
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (ext_low_i[i] || pin_drive_i[i].pull_down) begin
                pin_level_o[i] = 1'b0;
            end else if (pin_drive_i[i].very_weak_pu || pin_drive_i[i].weak_pu ||
                         pin_drive_i[i].strong_pu || ext_high_i[i]) begin
                pin_level_o[i] = 1'b1;
            end else begin
                pin_level_o[i] = float_pat[i];
            end
        end
    end
endmodule

// >>> tb/configurable_io_port_bank_test.sv
/*
 * Self-checking bench for io_port_bank with an external pin model.
 * Assumes FILTER_CYCLES is shortened to 2 and all drive at clock+1 ns.
 */
`timescale 1ns/1ps

module configurable_io_port_bank_test;
    import io_bank_pkg::*;

    // ==========================================================
    // Signals
    localparam int FILT = 2;
    logic                 clock_i  = 1'b0;
    logic                 rst_n_i  = 1'b0;
    logic [PIN_COUNT-1:0] wr_d     = '0;
    logic [PIN_COUNT-1:0] wr_en    = '0;
    logic [PIN_COUNT-1:0] hi_d     = '0;
    logic [PIN_COUNT-1:0] lo_d     = '0;
    logic [PIN_COUNT-1:0] m_en     = '0;
    logic                 ext_rst  = 1'b1;
    logic                 crys     = 1'b0;
    logic [PIN_COUNT-1:0] ext_low  = '0;
    logic [PIN_COUNT-1:0] ext_high = '1;
    logic [PIN_COUNT-1:0] level;
    pin_drive_s [PIN_COUNT-1:0] drv;
    logic [PIN_COUNT-1:0] rd;
    logic [PIN_COUNT-1:0] latch;
    logic [PIN_COUNT-1:0] hi;
    logic [PIN_COUNT-1:0] lo;
    logic                 irq_a;
    logic                 irq_b;
    logic                 tmr;
    logic [4:0]           usable;
    int                   fail_count = 0;
    int                   n_checks   = 0;

    always #10 clock_i = ~clock_i;

    io_port_bank #(.FILTER_CYCLES(FILT)) io_port_bank_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .latch_wr_data_i(wr_d),
        .latch_wr_en_i(wr_en), .mode_sel_hi_wr_i(hi_d), .mode_sel_lo_wr_i(lo_d),
        .mode_wr_en_i(m_en), .ext_reset_pin_en_i(ext_rst), .crystal_osc_en_i(crys),
        .pin_level_i(level), .pin_drive_o(drv), .port_read_o(rd), .latch_o(latch),
        .mode_sel_hi_o(hi), .mode_sel_lo_o(lo), .ext_irq_a_input_o(irq_a),
        .ext_irq_b_input_o(irq_b), .timer_a_count_input_o(tmr), .usable_pins_o(usable));

    pin_world_model pin_world_model_i (.clock_i(clock_i), .pin_drive_i(drv),
        .ext_low_i(ext_low), .ext_high_i(ext_high), .pin_level_o(level));

    // ==========================================================
    // Tasks
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_latch(input logic [PIN_COUNT-1:0] mask, input logic [PIN_COUNT-1:0] d);
        wr_en = mask;
        wr_d = d;
        tick(1);
        wr_en = '0;
    endtask

    task automatic set_mode(input logic [PIN_COUNT-1:0] mask, input logic [PIN_COUNT-1:0] h,
                            input logic [PIN_COUNT-1:0] l);
        m_en = mask;
        hi_d = h;
        lo_d = l;
        tick(1);
        m_en = '0;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Drive expected once pulses are over; assumes pin held high outside
    function automatic pin_drive_s exp_drv(input logic [1:0] m, input logic l);
        pin_drive_s d;
        d = '0;
        case (m)
            2'h0: d = '{l, l, 1'b0, ~l};
            2'h1: d = '{1'b0, 1'b0, l, ~l};
            2'h3: d.pull_down = ~l;
            default: d = '0;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Sequence
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end

    initial begin
        tick(3);
        rst_n_i = 1'b1;
        check(32'(hi), 32'h03FFFFFF);
        check(32'(lo), 32'h0);
        check(32'(|drv), 32'h0);
        $display("reset test done");
        for (int c = 0; c < 2; c++) begin
            for (int r = 0; r < 2; r++) begin
                crys = c[0];
                ext_rst = r[0];
                tick(1);
                check(32'(usable), 32'(26 - 2 * c - r));
            end
        end
        ext_rst = 1'b1;
        $display("pin count test done");
        for (int m = 0; m < 4; m++) begin
            for (int l = 0; l < 2; l++) begin
                set_mode(26'h1, 26'(m >> 1), 26'(m & 1));
                wr_latch(26'h1, 26'(l));
                tick(FILT + 4);
                check(32'({hi[0], lo[0]}), 32'(m));
                check(32'(drv[0]), 32'(exp_drv(2'(m), l[0])));
            end
        end
        $display("mode test done");
        set_mode(26'h6, 26'h4, 26'h4);
        wr_latch(26'h6, 26'h0);
        tick(FILT + 2);
        wr_latch(26'h6, 26'h6);
        check(32'(drv[1].strong_pu), 32'h1);
        check(32'(drv[2]), 32'h0);
        tick(1);
        check(32'(drv[1].strong_pu), 32'h1);
        tick(1);
        check(32'(drv[1].strong_pu), 32'h0);
        ext_low[1] = 1'b1;
        tick(FILT + 3);
        check(32'(drv[1]), 32'h8);
        check(32'({rd[1], latch[1]}), 32'h1);
        ext_low[1] = 1'b0;
        $display("pull-up test done");
        for (int m = 0; m < 4; m++) begin
            set_mode(26'h2C00, {PIN_COUNT{m[1]}}, {PIN_COUNT{m[0]}});
            check(32'({hi[13], lo[13]}), 32'h2);
            check(32'({hi[10], lo[10]}), (m < 2) ? 32'h2 : 32'(m));
            check(32'({hi[11], lo[11]}), (m < 2) ? 32'h2 : 32'(m));
            check(32'(drv[13]), 32'h0);
            tick(1);
        end
        $display("restricted pin test done");
        ext_low = 26'h1C10;
        #1;
        check(32'({tmr, irq_a, irq_b, rd[11]}), 32'h2);
        tick(FILT - 1);
        ext_low = '0;
        tick(FILT + 2);
        check(32'({rd[4], irq_b}), 32'h3);
        ext_low = 26'h1010;
        tick(FILT + 2);
        check(32'({rd[4], irq_b, latch[4]}), 32'h1);
        ext_low = '0;
        $display("filter test done");
        stop_test();
    end
endmodule
